// ==== verif/field_model.sv ====
// field switch and sensor model with optional contact chatter
`timescale 1ns/100ps
`default_nettype none
module field_model (
  input wire logic clock_i,
  input wire logic [15:0] level_i,
  input wire logic [15:0] chatter_i,
  output var logic [15:0] field_o
);
  integer seed = 39045;
  initial field_o = 16'h0000;
  // chatter flips the chosen lines at random each cycle
  always @(posedge clock_i) begin
    field_o <= level_i ^ (chatter_i & 16'($random(seed)));
  end
endmodule
`default_nettype wire

// ==== verif/nf_asserts.sv ====
// bus and filter checks on the noise filter ports
`timescale 1ns/100ps
`default_nettype none
`include "input_filter_defs.vh"
module nf_asserts (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic [`NUM_INPUTS-1:0] discrete_inputs_i,
  input wire logic [`NUM_INPUTS-1:0] filtered_inputs_o,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  logic [15:0] h1, h2, h3, h4, h5;
  wire req = wb_cyc_i & wb_stb_i;
  wire [15:0] f = filtered_inputs_o;
  wire [15:0] seen = ~(f ^ h2) | ~(f ^ h3) | ~(f ^ h4) | ~(f ^ h5);
  always @(posedge clock_i) begin
    h1 <= discrete_inputs_i;
    h2 <= h1;
    h3 <= h2;
    h4 <= h3;
    h5 <= h4;
  end
  property p_ack_once; wb_ack_o |=> !wb_ack_o; endproperty
  property p_ack_held; wb_ack_o |-> req; endproperty
  property p_ack_time; $rose(req) |-> ##[1:2] wb_ack_o; endproperty
  property p_ack_quiet; !req |=> !wb_ack_o; endproperty
  property p_filt_src; ((f ^ $past(f)) & ~seen) == 16'h0000; endproperty
  property p_filt_hold;
    (f == discrete_inputs_i && $stable(discrete_inputs_i)) [*4] |=> $stable(f);
  endproperty
  a_ack_once: assert property (p_ack_once) else $error("ack wider than a cycle");
  a_ack_held: assert property (p_ack_held) else $error("ack without request");
  a_ack_time: assert property (p_ack_time) else $error("ack late");
  a_ack_quiet: assert property (p_ack_quiet) else $error("ack while idle");
  a_filt_src: assert property (p_filt_src) else $error("output not from raw");
  a_filt_hold: assert property (p_filt_hold) else $error("output moved");
  c_ack: cover property (wb_ack_o);
  c_rise: cover property ($changed(f) && f != 16'h0000);
  c_fall: cover property ($changed(f) && f == 16'h0000);
endmodule
bind input_noise_filter nf_asserts u_chk (.clock_i(clock_i), .rst_i(rst_i),
  .discrete_inputs_i(discrete_inputs_i), .filtered_inputs_o(filtered_inputs_o),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o));
`default_nettype wire

// ==== verif/testbench.sv ====
// self-checking bench for the input noise filter
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0, rdat, v;
  logic [15:0] level = 16'h0, chatter = 16'h0, m;
  logic [3:0] sel = 4'hf;
  wire [31:0] dat_o;
  wire ack;
  wire [15:0] field, filt;
  integer mismatches = 0, n_checks = 0, seed = 39045, i, t, x;
  initial forever #12.5 clock_i = ~clock_i;
  field_model u_field (.clock_i(clock_i), .level_i(level), .chatter_i(chatter),
    .field_o(field));
  input_noise_filter dut (.clock_i(clock_i), .rst_i(rst_i), .discrete_inputs_i(field),
    .filtered_inputs_o(filt), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack));
  function [7:0] adr_of(input integer n);
    adr_of = 8'h40 + 8'(n * 4);
  endfunction
  function [31:0] sat(input [31:0] a);
    sat = (a > 32'h4e20) ? 32'h4e20 : a;
  endfunction
  task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task close_out;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    integer k;
    @(posedge clock_i);
    {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
    k = 0;
    @(posedge clock_i);
    while (ack !== 1'b1 && k < 20) begin
      k = k + 1;
      @(posedge clock_i);
    end
    if (ack !== 1'b1) begin
      mismatches++;
      close_out();
    end
    rdat = dat_o;
    {cyc, stb} <= 2'b00;
  endtask
  task wait_us(input integer n);
    repeat (n * 40) @(posedge clock_i);
  endtask
  initial begin
    repeat (8) @(posedge clock_i);
    rst_i <= 1'b0;
    wb(1'b0, 8'h00, 32'h0);
    chk("mode", rdat, 32'h0);
    wb(1'b0, 8'h20, 32'h0);
    chk("unmapped", rdat, 32'h0);
    for (i = 0; i < 16; i++) begin
      wb(1'b0, adr_of(i), 32'h0);
      chk("time reset", rdat, 32'h1);
    end
    for (i = 0; i < 16; i++) begin
      v = (i == 0) ? 32'h4e21 : (i == 1) ? 32'h0 : (i == 2) ? 32'h4e20 :
          (i == 3) ? 32'h0001_0005 : $random(seed) & 32'h7fff;
      wb(1'b1, adr_of(i), v);
      wb(1'b0, adr_of(i), 32'h0);
      chk("time", rdat, sat(v));
    end
    sel <= 4'hc;
    wb(1'b1, adr_of(15), sat(v) ^ 32'h1);
    sel <= 4'hf;
    wb(1'b0, adr_of(15), 32'h0);
    chk("sel", rdat, sat(v));
    $display("test registers done");
    wb(1'b1, 8'h00, 32'h1);
    wb(1'b0, 8'h00, 32'h0);
    chk("mode manual", rdat, 32'h1);
    for (i = 0; i < 4; i++) begin
      t = 3 + ($random(seed) & 7);
      x = $random(seed) & 14;
      m = 16'h3 << x;
      wb(1'b1, adr_of(x), 32'(t));
      wb(1'b1, adr_of(x + 1), 32'h0);
      wait_us(2);
      level <= m;
      wait_us(t - 2);
      chk("short hold", filt, 32'(16'h2 << x));
      wait_us(4);
      chk("full hold", filt, 32'(m));
      wb(1'b0, 8'h08, 32'h0);
      chk("raw", rdat, 32'(m));
      chatter <= 16'h1 << x;
      wait_us(t + 2);
      chk("chatter", filt, 32'(m));
      {chatter, level} <= 32'h0;
      wait_us(t + 2);
      chk("release", filt, 32'h0);
      wb(1'b0, 8'h0c, 32'h0);
      chk("noise", rdat, 32'h1 << x);
      wb(1'b1, 8'h0c, 32'hffff);
      wb(1'b0, 8'h0c, 32'h0);
      chk("noise clear", rdat, 32'h0);
    end
    $display("test manual done");
    wb(1'b1, 8'h00, 32'h0);
    level <= 16'h1 << x;
    wait_us(3);
    chk("default", filt, 32'h1 << x);
    wb(1'b0, 8'h04, 32'h0);
    chk("filtered reg", rdat, 32'h1 << x);
    $display("test default done");
    close_out();
  end
endmodule
`default_nettype wire

// ==== verilog/filter_time_ram.v ====
// per-input filter time store, one write port and two registered read ports
`timescale 1ns/100ps
`default_nettype none
`include "input_filter_defs.vh"

module filter_time_ram (
  input wire clock_i,
  input wire rst_i,
  input wire wr_en_i,
  input wire [`IDX_W-1:0] wr_addr_i,
  input wire [`TIME_W-1:0] wr_data_i,
  input wire [`IDX_W-1:0] rd_a_addr_i,
  output reg [`TIME_W-1:0] rd_a_data_o,
  input wire [`IDX_W-1:0] rd_b_addr_i,
  output reg [`TIME_W-1:0] rd_b_data_o
);

  reg [`TIME_W-1:0] mem_q [0:`NUM_INPUTS-1];
  integer k;

  // every entry starts at the default time
  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      for (k = 0; k < `NUM_INPUTS; k = k + 1) begin
        mem_q[k] <= `TIME_DEFAULT_US; // RULE2
      end
    end else if (wr_en_i) begin
      mem_q[wr_addr_i] <= wr_data_i; // RULE5
    end
  end

  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      rd_a_data_o <= {`TIME_W{1'b0}};
      rd_b_data_o <= {`TIME_W{1'b0}};
    end else begin
      rd_a_data_o <= mem_q[rd_a_addr_i];
      rd_b_data_o <= mem_q[rd_b_addr_i];
    end
  end

endmodule
`default_nettype wire

// ==== verilog/input_filter_defs.vh ====
// constants for the discrete input noise filter
`ifndef INPUT_FILTER_DEFS_VH
`define INPUT_FILTER_DEFS_VH

`define NUM_INPUTS 16
`define IDX_W 4
`define TIME_W 15
`define SCAN_LAST_IDX 4'hf

// clock rate and one microsecond tick
`define CLK_FREQ_HZ 40000000
`define US_PER_S 1000000
`define CYCLES_PER_US (`CLK_FREQ_HZ / `US_PER_S)
`define DIV_W 6
// last divider count, one less than the cycles in a microsecond
`define DIV_LAST_CNT 6'h27

// filter times in microseconds
`define TIME_DEFAULT_US 15'h0001
`define TIME_MAX_US 15'h4e20

// register byte addresses
`define ADR_W 8
`define REG_CTRL 8'h00
`define REG_FILTERED 8'h04
`define REG_RAW 8'h08
`define REG_NOISE 8'h0c
`define REG_TIME_BASE 8'h40
`define REG_TIME_MASK 8'hc0

// control register fields
`define CTRL_MODE_BIT 0
`define MODE_DEFAULT 1'b0
`define MODE_MANUAL 1'b1

// both low byte lanes must be enabled for 16-bit fields
`define SEL_LOW 2'b11

`endif

// ==== verilog/input_noise_filter.v ====
// sixteen-input noise filter with wishbone register access
// Summary of operation
// RULE1 - pulses shorter than filter time are dropped
// RULE2 - times 0 to 20000 us, default 1
// RULE3 - default mode uses built-in time everywhere
// RULE4 - manual mode uses each input's own time
// RULE5 - sixteen independent per-input filter times
// RULE6 - output follows after full stable time
//
// Chosen here: the Wishbone register port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
`include "input_filter_defs.vh"

module input_noise_filter (
  input wire clock_i,
  input wire rst_i,
  input wire [`NUM_INPUTS-1:0] discrete_inputs_i,
  output wire [`NUM_INPUTS-1:0] filtered_inputs_o,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [`ADR_W-1:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o
);

  localparam [1:0] SEQ_IDLE = 2'b01;
  localparam [1:0] SEQ_SCAN = 2'b10;
  localparam [`DIV_W-1:0] DIV_LAST = `DIV_LAST_CNT;
  localparam [`IDX_W-1:0] IDX_LAST = `SCAN_LAST_IDX;

  // true when the address falls in the filter time table
  function is_time_adr;
    input [`ADR_W-1:0] adr;
    begin
      is_time_adr = ((adr & `REG_TIME_MASK) == `REG_TIME_BASE);
    end
  endfunction

  // word index within the table
  function [`IDX_W-1:0] time_idx;
    input [`ADR_W-1:0] adr;
    begin
      time_idx = adr[`IDX_W+1:2];
    end
  endfunction

  // two-stage synchroniser on the field pins
  // the first stage feeds nothing but the second
  reg [`NUM_INPUTS-1:0] raw_meta_q;
  reg [`NUM_INPUTS-1:0] raw_sync_q;

  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      raw_meta_q <= {`NUM_INPUTS{1'b0}};
      raw_sync_q <= {`NUM_INPUTS{1'b0}};
    end else begin
      raw_meta_q <= discrete_inputs_i;
      raw_sync_q <= raw_meta_q;
    end
  end

  // one-microsecond tick
  reg [`DIV_W-1:0] div_q;
  wire us_tick;

  assign us_tick = (div_q == DIV_LAST);

  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      div_q <= {`DIV_W{1'b0}};
    end else if (us_tick) begin
      div_q <= {`DIV_W{1'b0}};
    end else begin
      div_q <= div_q + 1'b1;
    end
  end

  // bus slave: request seen, then answered one cycle later
  reg pend_q;
  reg mode_q;
  wire bus_req;
  wire bus_wr;
  wire time_wr;
  wire noise_clr;
  wire [`TIME_W-1:0] wr_time;
  wire wr_over;
  wire [`TIME_W-1:0] rd_b_data;

  assign bus_req = wb_cyc_i & wb_stb_i;
  // writes land on the edge where the master samples ack
  assign bus_wr = wb_ack_o & bus_req & wb_we_i;
  assign time_wr = bus_wr & is_time_adr(wb_adr_i) & (wb_sel_i[1:0] == `SEL_LOW);
  assign noise_clr = bus_wr & (wb_adr_i == `REG_NOISE) & (wb_sel_i[1:0] == `SEL_LOW);
  // anything above the largest time, upper bits included, saturates
  assign wr_over = (wb_dat_i > {17'h00000, `TIME_MAX_US});
  assign wr_time = wr_over ? `TIME_MAX_US : wb_dat_i[`TIME_W-1:0]; // RULE2

  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      pend_q <= 1'b0;
      wb_ack_o <= 1'b0;
    end else begin
      // no new request is seen while one is pending or in its ack cycle
      pend_q <= bus_req & ~pend_q & ~wb_ack_o;
      wb_ack_o <= pend_q & bus_req;
    end
  end

  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      mode_q <= `MODE_DEFAULT;
    end else if (bus_wr & (wb_adr_i == `REG_CTRL) & wb_sel_i[0]) begin
      // each input picks the new mode up at its next scan slot
      mode_q <= wb_dat_i[`CTRL_MODE_BIT];
    end
  end

  // scan sequencer: visits every input once per microsecond
  // an input's slots therefore fall exactly one microsecond apart
  reg [1:0] seq_q;
  reg [`IDX_W-1:0] scan_idx_q;
  reg proc_valid_q;
  reg [`IDX_W-1:0] proc_idx_q;
  wire [`TIME_W-1:0] rd_a_data;
  wire [`TIME_W-1:0] time_eff;

  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      seq_q <= SEQ_IDLE;
      scan_idx_q <= {`IDX_W{1'b0}};
    end else begin
      case (seq_q)
        SEQ_IDLE: begin
          scan_idx_q <= {`IDX_W{1'b0}};
          if (us_tick) begin
            seq_q <= SEQ_SCAN;
          end
        end
        SEQ_SCAN: begin
          if (scan_idx_q == IDX_LAST) begin
            seq_q <= SEQ_IDLE;
            scan_idx_q <= {`IDX_W{1'b0}};
          end else begin
            scan_idx_q <= scan_idx_q + 1'b1;
          end
        end
        default: begin
          seq_q <= SEQ_IDLE;
          scan_idx_q <= {`IDX_W{1'b0}};
        end
      endcase
    end
  end

  // the time store answers one cycle after the scan address
  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      proc_valid_q <= 1'b0;
      proc_idx_q <= {`IDX_W{1'b0}};
    end else begin
      proc_valid_q <= (seq_q == SEQ_SCAN);
      proc_idx_q <= scan_idx_q;
    end
  end

  // default mode ignores the entered times
  assign time_eff = (mode_q == `MODE_MANUAL) ? rd_a_data : `TIME_DEFAULT_US; // RULE3 RULE4

  // port a serves the scan, port b the bus reads
  filter_time_ram u_times (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .wr_en_i(time_wr),
    .wr_addr_i(time_idx(wb_adr_i)),
    .wr_data_i(wr_time),
    .rd_a_addr_i(scan_idx_q),
    .rd_a_data_o(rd_a_data),
    .rd_b_addr_i(time_idx(wb_adr_i)),
    .rd_b_data_o(rd_b_data)
  );

  // per-input filter channels
  wire [`NUM_INPUTS-1:0] filt_bus;
  wire [`NUM_INPUTS-1:0] noise_evt;
  genvar i;

  generate
    for (i = 0; i < `NUM_INPUTS; i = i + 1) begin : g_chan
      reg [`TIME_W-1:0] count_q;
      reg filt_q;
      reg zero_q;
      reg pend_q;
      reg acc_q;
      wire slot;
      wire [`TIME_W:0] count_inc;
      wire differs;

      assign slot = proc_valid_q & (proc_idx_q == i);
      assign count_inc = {1'b0, count_q} + {{`TIME_W{1'b0}}, 1'b1};
      assign differs = (raw_sync_q[i] != filt_q);

      // zero time is learnt in this input's scan slot
      always @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
          zero_q <= 1'b0;
        end else if (slot) begin
          zero_q <= (time_eff == {`TIME_W{1'b0}}); // RULE6
        end
      end

      always @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
          count_q <= {`TIME_W{1'b0}};
          filt_q <= 1'b0;
          acc_q <= 1'b0;
        end else if (!differs) begin
          // level fell back before the time ran out: drop it
          count_q <= {`TIME_W{1'b0}}; // RULE1
          acc_q <= 1'b0;
        end else if (zero_q) begin
          filt_q <= raw_sync_q[i]; // RULE6
          count_q <= {`TIME_W{1'b0}};
          acc_q <= 1'b1;
        end else if (slot) begin
          // the first slot may fall just after the change, so one extra
          // slot is counted to be sure the whole time has passed
          if (count_inc > {1'b0, time_eff}) begin // RULE1
            filt_q <= raw_sync_q[i]; // RULE6
            count_q <= {`TIME_W{1'b0}};
            acc_q <= 1'b1;
          end else begin
            count_q <= count_inc[`TIME_W-1:0]; // RULE1
            acc_q <= 1'b0;
          end
        end else begin
          acc_q <= 1'b0;
        end
      end

      always @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
          pend_q <= 1'b0;
        end else begin
          pend_q <= differs;
        end
      end

      // a change that returned without being accepted
      // acc_q marks the cycle right after an accepted change
      assign noise_evt[i] = pend_q & ~differs & ~acc_q; // RULE1
      assign filt_bus[i] = filt_q;
    end
  endgenerate

  assign filtered_inputs_o = filt_bus;

  // sticky rejected-pulse flags, write one to clear, set wins
  reg [`NUM_INPUTS-1:0] noise_q;
  wire [`NUM_INPUTS-1:0] noise_clr_mask;

  assign noise_clr_mask = noise_clr ? wb_dat_i[`NUM_INPUTS-1:0] : {`NUM_INPUTS{1'b0}};

  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      noise_q <= {`NUM_INPUTS{1'b0}};
    end else begin
      noise_q <= (noise_q & ~noise_clr_mask) | noise_evt;
    end
  end

  // read data, loaded on the answering edge
  reg [31:0] rd_mux;

  always @* begin
    // unused upper bits always read zero
    rd_mux = 32'h0000_0000;
    if (wb_adr_i == `REG_CTRL) begin
      rd_mux[`CTRL_MODE_BIT] = mode_q;
    end else if (wb_adr_i == `REG_FILTERED) begin
      rd_mux[`NUM_INPUTS-1:0] = filt_bus;
    end else if (wb_adr_i == `REG_RAW) begin
      rd_mux[`NUM_INPUTS-1:0] = raw_sync_q;
    end else if (wb_adr_i == `REG_NOISE) begin
      rd_mux[`NUM_INPUTS-1:0] = noise_q;
    end else if (is_time_adr(wb_adr_i)) begin
      rd_mux[`TIME_W-1:0] = rd_b_data;
    end
  end

  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (pend_q & bus_req & ~wb_we_i) begin
      wb_dat_o <= rd_mux;
    end
  end

endmodule
`default_nettype wire
